// file: lfr_consts.svh
// register offsets, field positions and reset values of control register three
`ifndef LFR_CONSTS_SVH
`define LFR_CONSTS_SVH
// word indices; the bus byte address is four times the index
`define LFR_CTL3_IDX       10'h022
`define LFR_MODE_IDX       10'h024
`define LFR_CTL3_ADDR      {`LFR_CTL3_IDX, 2'h0}
`define LFR_MODE_ADDR      {`LFR_MODE_IDX, 2'h0}
`define LFR_DO_BIT         7
`define LFR_TOG_BIT        6
`define LFR_SYNC_HI        5
`define LFR_SYNC_LO        4
`define LFR_CDT_HI         3
`define LFR_CDT_LO         0
`define LFR_TOG_RST        1'h0
`define LFR_SYNC_RST       2'h1
`define LFR_CDT_RST        4'h0
`define LFR_CARMODE_RST    1'h1
`define LFR_RESP_OKAY      2'h0
`define LFR_RESP_SLVERR    2'h2
`endif

// file: lfr_pkg.sv
// types shared by the control register three block
package lfr_pkg;
    // detector mode selected by the carrier/data mode bit
    typedef enum logic {
        lfr_data_mode_t_data    = 1'b0,
        lfr_data_mode_t_carrier = 1'b1
    } lfr_mode_t;
    // write channel progress of the bus slave
    typedef enum logic [1:0] {
        LFR_W_IDLE,
        LFR_W_RESP
    } lfr_wstate_t;
endpackage : lfr_pkg

// file: lfr_sync.sv
// two flip-flop synchroniser for the slicer level
`timescale 1ns/1ps
module lfr_sync (
    // clock
    input  wire logic aclk,
    // asynchronous level in, synchronised level out
    input  wire logic level_in,
    output logic      level_out
);
    logic stage_one;  // first stage, read only by the second

    // plain two-stage shift, no reset so the level is never disturbed
    always_ff @(posedge aclk) begin
        stage_one <= level_in;
        level_out <= stage_one;
    end
endmodule : lfr_sync

// file: lfr_ctl3.sv
// low-frequency receiver control register three with axi4-lite slave
//
// Functional notes
// [R1] 8-bit register at 0x0022, fixed field layout
// [R2] bit 7 reads slicer output, writes ignored
// [R3] detector bit unaffected by any reset
// [R4] bit 7 is 0 below, 1 above threshold
// [R5] bit 6 toggle enable, read/write, reset clears
// [R6] toggle off: mode bit holds, selects mode
// [R7] toggle on: mode inverts each sampling-on sequence
// [R8] mode 1 carrier detect, 0 data receive
// [R9] reset presets sync select to 01
// [R10] reset clears carrier detect time to zero
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "lfr_consts.svh"
module lfr_ctl3 import lfr_pkg::*; (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // write address channel
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // write data channel
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // write response channel
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // read address channel
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // read data channel
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // receiver side
    input  wire logic        slicer_level,
    input  wire logic        sampling_on_sequence,
    output logic             carrier_data_mode_select,
    output logic             carrier_detect_mode,
    output logic [1:0]       sync_pattern_select,
    output logic [3:0]       carrier_detect_time
);
    // synchronised inputs
    logic        detector_output_level;  // live slicer level
    logic        seq_sync;               // synchronised sequence level
    logic        seq_prev;               // previous sequence level
    logic        seq_end;                // falling edge, sequence over
    // register state
    logic        mode_toggle_enable;
    logic        next_mode_toggle_enable;
    logic        next_carrier_data_mode_select;
    logic [1:0]  next_sync_pattern_select;
    logic [3:0]  next_carrier_detect_time;
    // write channel state
    logic        aw_held;
    logic        next_aw_held;
    logic [11:0] aw_addr;
    logic [11:0] next_aw_addr;
    logic        w_held;
    logic        next_w_held;
    logic [7:0]  w_byte;
    logic [7:0]  next_w_byte;
    logic        w_strb0;
    logic        next_w_strb0;
    logic        next_bvalid;
    logic [1:0]  next_bresp;
    logic        wr_fire;                // both halves present
    // read channel state
    logic        next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;
    logic [7:0]  ctl3_view;              // register as read

    // slicer level, no reset on the path [R3]
    lfr_sync u_do_sync (
        .aclk      (aclk),
        .level_in  (slicer_level),
        .level_out (detector_output_level)
    );

    // sampling-on sequence level from the receiver sequencer
    lfr_sync u_seq_sync (
        .aclk      (aclk),
        .level_in  (sampling_on_sequence),
        .level_out (seq_sync)
    );

    // edge history of the sequence level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seq_prev <= 1'b0;
        end else begin
            seq_prev <= seq_sync;
        end
    end
    // flip only once a sequence is over, so each sequence runs in the
    // mode it began with and the first one uses software's choice [R7]
    assign seq_end = ~seq_sync & seq_prev;

    // register view: bit 7 live, 1 above threshold [R2] [R4] [R1]
    assign ctl3_view = {detector_output_level, mode_toggle_enable,
                        sync_pattern_select, carrier_detect_time};

    // 1 selects carrier detect, 0 data receive [R8]
    assign carrier_detect_mode =
        (carrier_data_mode_select == lfr_data_mode_t_carrier);

    // write handshake: address and data taken in either order
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
    assign wr_fire       = (aw_held | s_axi_awvalid)
                         & (w_held | s_axi_wvalid) & ~s_axi_bvalid;

    // next values for write channel and control fields
    always_comb begin
        logic [11:0] addr;
        logic [7:0]  data;
        logic        strb;
        addr = aw_held ? aw_addr : s_axi_awaddr;
        data = w_held ? w_byte : s_axi_wdata[7:0];
        strb = w_held ? w_strb0 : s_axi_wstrb[0];
        next_aw_held  = aw_held;
        next_aw_addr  = aw_addr;
        next_w_held   = w_held;
        next_w_byte   = w_byte;
        next_w_strb0  = w_strb0;
        next_bvalid   = s_axi_bvalid;
        next_bresp    = s_axi_bresp;
        next_mode_toggle_enable       = mode_toggle_enable;
        next_sync_pattern_select      = sync_pattern_select;
        next_carrier_detect_time      = carrier_detect_time;
        next_carrier_data_mode_select = carrier_data_mode_select;
        // mode held while toggle off; inverts per sequence when on
        if (seq_end && mode_toggle_enable) begin
            next_carrier_data_mode_select = ~carrier_data_mode_select; // [R7]
        end else begin
            next_carrier_data_mode_select = carrier_data_mode_select; // [R6]
        end
        // answer accepted, free the channel
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (wr_fire) begin
            // complete write: decode and respond
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = `LFR_RESP_OKAY;
            if (addr == `LFR_CTL3_ADDR) begin
                // bit 7 write discarded [R2]
                if (strb) begin
                    next_mode_toggle_enable  = data[`LFR_TOG_BIT]; // [R5]
                    next_sync_pattern_select =
                        data[`LFR_SYNC_HI:`LFR_SYNC_LO];
                    next_carrier_detect_time =
                        data[`LFR_CDT_HI:`LFR_CDT_LO];
                end
            end else if (addr == `LFR_MODE_ADDR) begin
                // software mode selection; first sequence uses it [R7]
                if (strb) begin
                    next_carrier_data_mode_select = data[0];
                end
            end else begin
                next_bresp = `LFR_RESP_SLVERR;
            end
        end else begin
            // hold whichever half arrived first
            if (s_axi_awvalid && s_axi_awready) begin
                next_aw_held = 1'b1;
                next_aw_addr = s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                next_w_held  = 1'b1;
                next_w_byte  = s_axi_wdata[7:0];
                next_w_strb0 = s_axi_wstrb[0];
            end
        end
    end

    // write channel and control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held  <= 1'b0;
            aw_addr  <= 12'h000;
            w_held   <= 1'b0;
            w_byte   <= 8'h00;
            w_strb0  <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `LFR_RESP_OKAY;
            mode_toggle_enable       <= `LFR_TOG_RST;     // [R5]
            sync_pattern_select      <= `LFR_SYNC_RST;    // [R9]
            carrier_detect_time      <= `LFR_CDT_RST;     // [R10]
            carrier_data_mode_select <= `LFR_CARMODE_RST;
        end else begin
            aw_held  <= next_aw_held;
            aw_addr  <= next_aw_addr;
            w_held   <= next_w_held;
            w_byte   <= next_w_byte;
            w_strb0  <= next_w_strb0;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp  <= next_bresp;
            mode_toggle_enable       <= next_mode_toggle_enable;
            sync_pattern_select      <= next_sync_pattern_select;
            carrier_detect_time      <= next_carrier_detect_time;
            carrier_data_mode_select <= next_carrier_data_mode_select;
        end
    end

    // read channel: ready while no answer is pending
    assign s_axi_arready = ~s_axi_rvalid;

    // next values for read channel
    always_comb begin
        next_rvalid = s_axi_rvalid;
        next_rdata  = s_axi_rdata;
        next_rresp  = s_axi_rresp;
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = `LFR_RESP_OKAY;
            if (s_axi_araddr == `LFR_CTL3_ADDR) begin
                next_rdata = {24'h000000, ctl3_view}; // [R1] [R2]
            end else if (s_axi_araddr == `LFR_MODE_ADDR) begin
                next_rdata = {31'h00000000, carrier_data_mode_select};
            end else begin
                next_rdata = 32'h00000000;
                next_rresp = `LFR_RESP_SLVERR;
            end
        end
    end

    // read channel registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `LFR_RESP_OKAY;
        end else begin
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= next_rresp;
        end
    end
endmodule : lfr_ctl3

// file: lfr_ctl3_properties.sv
// assertion checker for control register three
`timescale 1ns/1ps
`include "lfr_consts.svh"
module lfr_ctl3_props (
    // clock, reset and one-bit signals
    input wire logic        aclk, aresetn, s_axi_awvalid, s_axi_awready,
    input wire logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid,
    input wire logic        s_axi_bready, s_axi_arvalid, s_axi_arready,
    input wire logic        s_axi_rvalid, s_axi_rready, slicer_level,
    input wire logic        sampling_on_sequence, carrier_detect_mode,
    input wire logic        carrier_data_mode_select,
    // buses
    input wire logic [11:0] s_axi_awaddr, s_axi_araddr,
    input wire logic [31:0] s_axi_wdata, s_axi_rdata,
    input wire logic [3:0]  s_axi_wstrb, carrier_detect_time,
    input wire logic [1:0]  s_axi_bresp, s_axi_rresp, sync_pattern_select
);
    logic [5:0] son_h;  // sampling-on history, bit 0 newest
    logic [4:0] sl_h;   // slicer history, bit 0 newest
    logic       son_fall;  // a falling edge within the last few cycles
    default clocking cb @(posedge aclk); endclocking
    // history registers for the asynchronous receiver inputs
    always_ff @(posedge aclk) begin
        son_h <= {son_h[4:0], sampling_on_sequence};
        sl_h  <= {sl_h[3:0], slicer_level};
    end
    assign son_fall = |(~son_h[4:0] & son_h[5:1]);
    AST_MODE_DECODE: assert property (disable iff (!aresetn)
        carrier_detect_mode == carrier_data_mode_select)
        else $error("mode decode wrong");
    AST_SYNC_RST: assert property (!aresetn |=>
        sync_pattern_select == `LFR_SYNC_RST)
        else $error("sync select not preset");
    AST_CDT_RST: assert property (!aresetn |=>
        carrier_detect_time == `LFR_CDT_RST)
        else $error("detect time not cleared");
    AST_MODE_CAUSE: assert property (disable iff (!aresetn)
        $changed(carrier_data_mode_select) |-> son_fall || $rose(s_axi_bvalid))
        else $error("mode changed without cause");
    AST_DETECT: assert property (disable iff (!aresetn)
        $rose(s_axi_rvalid) && $past(s_axi_araddr) == `LFR_CTL3_ADDR
        && (&sl_h || ~|sl_h) |-> s_axi_rdata[7] == sl_h[0])
        else $error("detector bit wrong");
    AST_UPPER: assert property (disable iff (!aresetn)
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    AST_RD_LAT: assert property (disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_SLVERR: assert property (disable iff (!aresetn)
        $rose(s_axi_rvalid) && $past(s_axi_araddr) != `LFR_CTL3_ADDR
        && $past(s_axi_araddr) != `LFR_MODE_ADDR
        |-> s_axi_rresp == `LFR_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read wrong");
    AST_FIELD_CAUSE: assert property (disable iff (!aresetn)
        $changed({sync_pattern_select, carrier_detect_time})
        |-> $rose(s_axi_bvalid))
        else $error("field changed without write");
    // main scenarios
    cover property (disable iff (!aresetn) $rose(s_axi_bvalid));
    cover property (disable iff (!aresetn) $rose(s_axi_rvalid));
    cover property (disable iff (!aresetn)
        son_fall && $changed(carrier_data_mode_select));
endmodule : lfr_ctl3_props

// file: tb_top.sv
// self-checking bench for control register three
`timescale 1ns/1ps
`include "lfr_consts.svh"
module tb_top;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_arready, s_axi_rvalid, s_axi_rready, slicer_level;
    logic        sampling_on_sequence, carrier_detect_mode;
    logic        carrier_data_mode_select;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d, got;
    logic [3:0]  s_axi_wstrb, carrier_detect_time;
    logic [1:0]  s_axi_bresp, s_axi_rresp, sync_pattern_select, rsp;
    integer      err_total = 0, checks_done = 0, seed = 32'h212e1a46, i;
    integer      m_tog, m_sync, m_cdt, m_mode;  // reference model fields
    lfr_ctl3 dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .slicer_level,
        .sampling_on_sequence, .carrier_data_mode_select,
        .carrier_detect_mode, .sync_pattern_select, .carrier_detect_time);
    // clock
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    // verdict
    task automatic close_out;
        if (err_total == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out
    // expected register word for a given slicer level
    function automatic logic [31:0] ctl(input logic lvl);
        return {24'h0, lvl, m_tog[0], m_sync[1:0], m_cdt[3:0]};
    endfunction : ctl
    // reset for 20 cycles, model back to reset values
    task automatic do_reset;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        m_tog = 0;
        m_sync = 1;
        m_cdt = 0;
        m_mode = 1;
    endtask : do_reset
    // bus write with model update and response check
    task automatic mw(input logic [11:0] a, input logic [31:0] dd,
                      input logic [3:0] s);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= dd;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        if (a == `LFR_CTL3_ADDR && s[0]) begin
            m_tog = dd[6];
            m_sync = dd[5:4];
            m_cdt = dd[3:0];
        end
        if (a == `LFR_MODE_ADDR && s[0]) m_mode = dd[0];
        chk(s_axi_bresp, (a == `LFR_CTL3_ADDR || a == `LFR_MODE_ADDR) ?
            `LFR_RESP_OKAY : `LFR_RESP_SLVERR);
    endtask : mw
    // bus read into got and rsp
    task automatic rd(input logic [11:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        got = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask : rd
    // one sampling-on sequence, then check the mode outputs
    task automatic pulse;
        @(posedge aclk);
        sampling_on_sequence <= 1'b1;
        repeat (5) @(posedge aclk);
        chk(carrier_data_mode_select, m_mode);
        sampling_on_sequence <= 1'b0;
        repeat (5) @(posedge aclk);
        if (m_tog) m_mode = 1 - m_mode;
        chk(carrier_data_mode_select, m_mode);
        chk(carrier_detect_mode, m_mode);
    endtask : pulse
    // watchdog
    initial begin
        #(40 * 5000);
        err_total++;
        close_out;
    end
    // main sequence
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
        {s_axi_bready, s_axi_rready} = 2'h3;
        {slicer_level, sampling_on_sequence} = 2'h0;
        do_reset;
        for (i = 0; i < 14; i++) begin
            d = $random(seed);
            slicer_level <= d[31];
            if (i > 1) mw(`LFR_CTL3_ADDR, d, d[11:8]);
            repeat (4) @(posedge aclk);
            rd(`LFR_CTL3_ADDR);
            chk(got, ctl(d[31]));
            d = {sync_pattern_select, carrier_detect_time};
            chk(d, m_sync * 16 + m_cdt);
        end
        mw(12'h030, 32'hff, 4'hf);
        rd(12'h030);
        chk(got, 32'h0);
        chk(rsp, `LFR_RESP_SLVERR);
        mw(`LFR_CTL3_ADDR, 32'h10, 4'hf);
        mw(`LFR_MODE_ADDR, 32'h0, 4'hf);
        rd(`LFR_MODE_ADDR);
        chk(got, m_mode);
        pulse;
        pulse;
        mw(`LFR_CTL3_ADDR, 32'h50, 4'hf);
        for (i = 0; i < 3; i++) pulse;
        slicer_level <= 1'b1;
        do_reset;
        repeat (4) @(posedge aclk);
        rd(`LFR_CTL3_ADDR);
        chk(got, ctl(1'b1));
        chk(carrier_data_mode_select, 32'h1);
        close_out;
    end
endmodule : tb_top
bind lfr_ctl3 lfr_ctl3_props u_props (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .slicer_level, .sampling_on_sequence, .carrier_data_mode_select,
    .carrier_detect_mode, .sync_pattern_select, .carrier_detect_time);
